// file: hsc_err_regs.svh
// offsets-free constants for the counter error monitor: codes and timing
`ifndef HSC_ERR_REGS_SVH
`define HSC_ERR_REGS_SVH
`define CODE_NONE        16'h0000
`define CODE_CNT_LOST    16'h1605
`define CODE_SET_LOST    16'h1606
`define CODE_CFG_BAD     16'h1607
`define CODE_OVF_BASE    16'h1800
`define CODE_LIM_BASE    16'h1802
`define CODE_JMP_BASE    16'h1804
`define CODE_COM_BASE    16'h1806
`define CODE_ZRO_BASE    16'h1808
`define BLINK_PERIOD_MS  500
`define CLK_MHZ          250
`define BLINK_HALF_CYC   ((`BLINK_PERIOD_MS * 1000 * `CLK_MHZ) / 2)
`endif

// file: hsc_err_pkg.sv
// types for the counter error monitor
package hsc_err_pkg;
	// per-channel events in one bundle
	typedef struct packed {
		logic ovf;       // overflow or underflow seen
		logic ovf_clr;   // clear, reset, preset, restart or run instruction
		logic lim;       // linear count beyond limit
		logic wrap;      // accumulated count wrapped max to min
		logic rd_vld;    // ssi reading done
		logic rd_jump;   // reading delta beyond limit
		logic com_err;   // ssi frame fault or parity failure
		logic zero_x;    // ssi position crossed zero
	} chan_evt_t;
	// alarm enables per channel
	typedef struct packed {
		logic ovf_alarm_en;
		logic zero_alarm_en;
	} chan_cfg_t;
	typedef enum logic [1:0] {
		LED_OFF   = 2'b00,
		LED_ON    = 2'b01,
		LED_BLINK = 2'b10
	} led_mode_t;
endpackage

// file: hsc_error_status_monitor.sv
// error and warning code monitor for a two-channel high-speed counter
`timescale 1ns/1ns
`include "hsc_err_regs.svh"

module hsc_error_status_monitor #(
	parameter int unsigned BLINK_HALF = `BLINK_HALF_CYC
) (
	// clock, reset, enable
	input  wire logic                     MCLK,
	input  wire logic                     NRST,
	input  wire logic                     CE,
	// major fault sources and the download that clears settings loss
	input  wire logic                     CNT_RETAIN_LOST,
	input  wire logic                     SET_RETAIN_LOST,
	input  wire logic                     CFG_MISMATCH,
	input  wire logic                     CFG_DOWNLOAD,
	// per-channel events and configuration
	input  wire hsc_err_pkg::chan_evt_t   CH1_EVT,
	input  wire hsc_err_pkg::chan_evt_t   CH2_EVT,
	input  wire hsc_err_pkg::chan_cfg_t   CH1_CFG,
	input  wire hsc_err_pkg::chan_cfg_t   CH2_CFG,
	// status out
	output logic [15:0]                   ERR_CODE,
	output logic                          ERR_LED,
	output logic                          MAJOR_STOP,
	output logic                          WARN_ACTIVE
);

	//////////////////////////////////////////////////////////////////////
	// sticky flags except cfg_bad_ff, which follows CFG_MISMATCH: index 0 ch1, 1 ch2
	logic       cnt_lost_ff, nxt_cnt_lost;
	logic       set_lost_ff, nxt_set_lost;
	logic       cfg_bad_ff,  nxt_cfg_bad;
	logic [1:0] ovf_ff, nxt_ovf;
	logic [1:0] lim_ff, nxt_lim;
	logic [1:0] jmp_ff, nxt_jmp;
	logic [1:0] com_ff, nxt_com;
	logic [1:0] zro_ff, nxt_zro;
	hsc_err_pkg::chan_evt_t evt [2];
	hsc_err_pkg::chan_cfg_t cfg [2];

	assign evt[0] = CH1_EVT;
	assign evt[1] = CH2_EVT;
	assign cfg[0] = CH1_CFG;
	assign cfg[1] = CH2_CFG;

	// major flags; lost-count lives only until power cycle, i.e. reset
	always_comb begin
		nxt_cnt_lost = cnt_lost_ff | CNT_RETAIN_LOST;
		// set wins over clear so a loss during download is not dropped
		nxt_set_lost = SET_RETAIN_LOST | (set_lost_ff & ~CFG_DOWNLOAD);
		nxt_cfg_bad  = CFG_MISMATCH;
	end

	// the settings-loss source is expected to reassert after power-up,
	// since this flop cannot itself survive NRST
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			cnt_lost_ff <= 1'b0;
			set_lost_ff <= 1'b0;
			cfg_bad_ff  <= 1'b0;
		end else if (CE) begin
			cnt_lost_ff <= nxt_cnt_lost;
			set_lost_ff <= nxt_set_lost;
			cfg_bad_ff  <= nxt_cfg_bad;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// per-channel warning flags
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			always_comb begin
				nxt_ovf[gi] = (evt[gi].ovf & cfg[gi].ovf_alarm_en)
				              | (ovf_ff[gi] & ~evt[gi].ovf_clr);
				nxt_lim[gi] = evt[gi].lim | (lim_ff[gi] & ~evt[gi].wrap);
				nxt_jmp[gi] = evt[gi].rd_vld ? evt[gi].rd_jump : jmp_ff[gi];
				nxt_com[gi] = evt[gi].com_err | (com_ff[gi] & ~evt[gi].rd_vld);
				nxt_zro[gi] = (evt[gi].zero_x & cfg[gi].zero_alarm_en)
				              | (zro_ff[gi] & ~evt[gi].ovf_clr);
			end
		end
	endgenerate

	// a good reading also retires a stale communication fault
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ovf_ff <= 2'b00;
			lim_ff <= 2'b00;
			jmp_ff <= 2'b00;
			com_ff <= 2'b00;
			zro_ff <= 2'b00;
		end else if (CE) begin
			ovf_ff <= nxt_ovf;
			lim_ff <= nxt_lim;
			jmp_ff <= nxt_jmp;
			com_ff <= nxt_com;
			zro_ff <= nxt_zro;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// code priority: majors first, then warnings by kind, ch1 before ch2 within each kind
	logic [15:0] nxt_code, code_ff;
	logic        major, warn;

	assign major = cnt_lost_ff | set_lost_ff | cfg_bad_ff;
	assign warn  = |{ovf_ff, lim_ff, jmp_ff, com_ff, zro_ff};

	always_comb begin
		nxt_code = `CODE_NONE;
		if (cnt_lost_ff)      nxt_code = `CODE_CNT_LOST;
		else if (set_lost_ff) nxt_code = `CODE_SET_LOST;
		else if (cfg_bad_ff)  nxt_code = `CODE_CFG_BAD;
		else if (ovf_ff[0])   nxt_code = `CODE_OVF_BASE;
		else if (ovf_ff[1])   nxt_code = `CODE_OVF_BASE + 16'h0001;
		else if (lim_ff[0])   nxt_code = `CODE_LIM_BASE;
		else if (lim_ff[1])   nxt_code = `CODE_LIM_BASE + 16'h0001;
		else if (jmp_ff[0])   nxt_code = `CODE_JMP_BASE;
		else if (jmp_ff[1])   nxt_code = `CODE_JMP_BASE + 16'h0001;
		else if (com_ff[0])   nxt_code = `CODE_COM_BASE;
		else if (com_ff[1])   nxt_code = `CODE_COM_BASE + 16'h0001;
		else if (zro_ff[0])   nxt_code = `CODE_ZRO_BASE;
		else if (zro_ff[1])   nxt_code = `CODE_ZRO_BASE + 16'h0001;
	end

	//////////////////////////////////////////////////////////////////////
	// indicator: steady for majors, 0.5 s blink for warnings
	hsc_err_pkg::led_mode_t mode;
	logic [31:0] blink_cnt_ff, nxt_blink_cnt;
	logic        blink_ff, nxt_blink;
	logic        led_ff, nxt_led;
	logic        stop_ff, nxt_stop;

	always_comb begin
		if (major)     mode = hsc_err_pkg::LED_ON;
		else if (warn) mode = hsc_err_pkg::LED_BLINK;
		else           mode = hsc_err_pkg::LED_OFF;
	end

	always_comb begin
		nxt_blink_cnt = blink_cnt_ff;
		nxt_blink     = blink_ff;
		if (mode != hsc_err_pkg::LED_BLINK) begin
			nxt_blink_cnt = 32'h0000_0000;
			nxt_blink     = 1'b1;
		end else if (blink_cnt_ff >= BLINK_HALF - 1) begin
			nxt_blink_cnt = 32'h0000_0000;
			nxt_blink     = ~blink_ff;
		end else begin
			nxt_blink_cnt = blink_cnt_ff + 32'h0000_0001;
		end
		case (mode)
			hsc_err_pkg::LED_ON:    nxt_led = 1'b1;
			hsc_err_pkg::LED_BLINK: nxt_led = blink_ff;
			default:                nxt_led = 1'b0;
		endcase
		nxt_stop = major;
	end

	// warnings never assert the stop line, so cpu and module keep running
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			code_ff      <= 16'h0000;
			blink_cnt_ff <= 32'h0000_0000;
			blink_ff     <= 1'b1;
			led_ff       <= 1'b0;
			stop_ff      <= 1'b0;
		end else if (CE) begin
			code_ff      <= nxt_code;
			blink_cnt_ff <= nxt_blink_cnt;
			blink_ff     <= nxt_blink;
			led_ff       <= nxt_led;
			stop_ff      <= nxt_stop;
		end
	end

	assign ERR_CODE    = code_ff;
	assign ERR_LED     = led_ff;
	assign MAJOR_STOP  = stop_ff;
	assign WARN_ACTIVE = warn & ~major;

	//////////////////////////////////////////////////////////////////////
	// assertion helper: enabled samples for which the indicator has kept its
	// level while only warnings are up; leaving steady mode may add one sample
	logic [31:0] hold_cnt_ff, nxt_hold_cnt;
	logic        led_seen_ff, nxt_led_seen;

	always_comb begin
		nxt_led_seen = ERR_LED;
		if (!warn || major)              nxt_hold_cnt = 32'h0000_0000;
		else if (ERR_LED != led_seen_ff) nxt_hold_cnt = 32'h0000_0001;
		else                             nxt_hold_cnt = hold_cnt_ff + 32'h0000_0001;
	end

	// counts only while enabled, as the indicator itself is frozen otherwise
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			hold_cnt_ff <= 32'h0000_0000;
			led_seen_ff <= 1'b0;
		end else if (CE) begin
			hold_cnt_ff <= nxt_hold_cnt;
			led_seen_ff <= nxt_led_seen;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// assertions
	// major errors
	a_major_stops: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CFG_MISMATCH ##1 CE |=> MAJOR_STOP && ERR_LED)
		else $error("config mismatch did not stop and light led");
	a_lost_code: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CNT_RETAIN_LOST ##1 CE |=> ERR_CODE == `CODE_CNT_LOST)
		else $error("lost count code not shown");
	a_cfg_follow: assert property (@(posedge MCLK) disable iff (!NRST)
		CE |=> cfg_bad_ff == $past(CFG_MISMATCH))
		else $error("mismatch flag does not follow its input");
	a_cnt_sticky: assert property (@(posedge MCLK) disable iff (!NRST)
		cnt_lost_ff |=> cnt_lost_ff)
		else $error("lost count code cleared without power cycle");
	a_set_hold: assert property (@(posedge MCLK) disable iff (!NRST)
		$fell(set_lost_ff) |-> $past(CFG_DOWNLOAD))
		else $error("settings loss cleared without download");
	a_set_wins: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && SET_RETAIN_LOST |=> set_lost_ff)
		else $error("settings loss dropped by a download");
	// channel warnings
	a_ovf_ch2: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && !major && ovf_ff == 2'b10 |=> ERR_CODE == 16'h1801)
		else $error("ch2 overflow code wrong");
	a_ovf_set: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CH2_EVT.ovf && CH2_CFG.ovf_alarm_en |=> ovf_ff[1])
		else $error("ch2 overflow warning not raised");
	a_ovf_mask: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && !ovf_ff[0] && !CH1_CFG.ovf_alarm_en |=> !ovf_ff[0])
		else $error("disabled overflow alarm raised");
	a_zero_mask: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && !zro_ff[1] && !CH2_CFG.zero_alarm_en |=> !zro_ff[1])
		else $error("disabled zero-crossing alarm raised");
	a_ovf_clear: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CH1_EVT.ovf_clr && !CH1_EVT.ovf |=> !ovf_ff[0])
		else $error("overflow warning not cleared");
	a_lim_set: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CH1_EVT.lim |=> lim_ff[0])
		else $error("limit warning not raised");
	a_lim_wrap: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CH2_EVT.wrap && !CH2_EVT.lim |=> !lim_ff[1])
		else $error("limit warning survived wrap");
	a_jmp_follow: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CH1_EVT.rd_vld |=> jmp_ff[0] == $past(CH1_EVT.rd_jump))
		else $error("jump flag does not follow reading");
	a_com_set: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CH2_EVT.com_err |=> com_ff[1])
		else $error("communication fault not raised");
	a_com_clear: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CH1_EVT.rd_vld && !CH1_EVT.com_err |=> !com_ff[0])
		else $error("communication fault survived a good reading");
	a_zero_set: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && CH1_EVT.zero_x && CH1_CFG.zero_alarm_en |=> zro_ff[0])
		else $error("zero-crossing warning not raised");
	// indicator and status outputs
	a_blink_half: assert property (@(posedge MCLK) disable iff (!NRST)
		hold_cnt_ff <= BLINK_HALF + 1)
		else $error("warning indicator held its level too long");
	a_major_steady: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && major |=> ERR_LED)
		else $error("major error did not light indicator");
	a_warn_no_stop: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && !major |=> !MAJOR_STOP)
		else $error("warning stopped the cpu");
	a_warn_code: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && !major && warn |=> ERR_CODE[15:8] == 8'h18)
		else $error("warning shown with a non-warning code");
	a_idle_zero: assert property (@(posedge MCLK) disable iff (!NRST)
		CE && !major && !warn |=> ERR_CODE == 16'h0000)
		else $error("code not zero when idle");
	a_frozen: assert property (@(posedge MCLK) disable iff (!NRST)
		!CE |=> $stable(ERR_CODE) && $stable(ERR_LED) && $stable(MAJOR_STOP))
		else $error("outputs moved while clock enable low");
	// main scenarios
	c_major: cover property (@(posedge MCLK) disable iff (!NRST) $rose(MAJOR_STOP));
	c_blink: cover property (@(posedge MCLK) disable iff (!NRST) warn && $fell(ERR_LED));
	c_com: cover property (@(posedge MCLK) disable iff (!NRST) ERR_CODE == 16'h1807);
	c_zero: cover property (@(posedge MCLK) disable iff (!NRST) ERR_CODE == 16'h1808);
	c_lim: cover property (@(posedge MCLK) disable iff (!NRST) ERR_CODE == 16'h1803);

endmodule

// file: cpu_bus_model.sv
// cpu-side model: issues settings downloads, halts on a major
`timescale 1ns/1ns
module cpu_bus_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// bench request and module status
	input  wire logic dl_req,
	input  wire logic major_stop,
	// download strobe and cpu state
	output logic      cfg_download,
	output logic      halted
);
	//////////////////////////////////////////////////////////////
	// strobe is the request delayed one cycle, low in reset so no stray clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cfg_download <= 1'b0;
		end else begin
			cfg_download <= dl_req;
		end
	end
	// a major stops the cpu, a warning leaves it running
	assign halted = major_stop;
endmodule

// file: hsc_error_status_monitor_tb.sv
// self-checking bench for the counter error monitor
`timescale 1ns/1ns
module hsc_error_status_monitor_tb;
	// stimulus and observed nets
	logic mclk = 0, nrst = 0, ce = 1, cnt_lost = 0, set_lost = 0, cfg_bad = 0, dl_req = 0;
	hsc_err_pkg::chan_evt_t ch1 = '0, ch2 = '0;
	hsc_err_pkg::chan_cfg_t cfg1 = 2'h3, cfg2 = 2'h3;
	wire logic [15:0] code;
	wire logic led, stop, warn, dl, halted;
	// scoreboard and bookkeeping
	logic [15:0] q[$];
	logic [15:0] e;
	int n_mismatch = 0, comparisons = 0, seed = 92048, cyc = 0, tog;
	logic armed = 0, led_q;
	logic [7:0] set_e [5] = '{8'h80, 8'h20, 8'h0c, 8'h0a, 8'h01};
	logic [7:0] clr_e [5] = '{8'h40, 8'h10, 8'h08, 8'h08, 8'h40};
	//////////////////////////////////////////////////////////////
	always #2 mclk = ~mclk;
	cpu_bus_model cpu_bus_model_inst (.mclk(mclk), .nrst(nrst), .dl_req(dl_req), .major_stop(stop),
		.cfg_download(dl), .halted(halted));
	hsc_error_status_monitor #(.BLINK_HALF(4)) hsc_error_status_monitor_inst (.MCLK(mclk), .NRST(nrst),
		.CE(ce), .CNT_RETAIN_LOST(cnt_lost), .SET_RETAIN_LOST(set_lost), .CFG_MISMATCH(cfg_bad),
		.CFG_DOWNLOAD(dl), .CH1_EVT(ch1), .CH2_EVT(ch2), .CH1_CFG(cfg1), .CH2_CFG(cfg2),
		.ERR_CODE(code), .ERR_LED(led), .MAJOR_STOP(stop), .WARN_ACTIVE(warn));
	//////////////////////////////////////////////////////////////
	// code compare, counts every check
	task automatic chk_code(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (exp !== got) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// single status line compare
	task automatic chk_flag(input string what, input logic exp, input logic got);
		comparisons++;
		if (exp !== got) begin
			n_mismatch++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	// counts: indicator toggles and scoreboard notes
	task automatic chk_count(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (exp !== got) begin
			n_mismatch++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// random idle, always long enough for the two-edge answer
	task automatic gap();
		repeat (3 + ($random(seed) & 3)) @(negedge mclk);
	endtask
	// one-cycle event pulse on a channel
	task automatic evt(input int ch, input logic [7:0] v);
		if (ch == 0) ch1 = v;
		else ch2 = v;
		@(negedge mclk);
		ch1 = '0;
		ch2 = '0;
		gap();
	endtask
	// count indicator changes over sixteen cycles
	task automatic blinks(input logic [15:0] exp_tog);
		tog = 0;
		@(posedge mclk);
		#1;
		led_q = led;
		repeat (16) begin
			@(posedge mclk);
			#1;
			tog += (led !== led_q);
			led_q = led;
		end
		chk_count("led toggles", exp_tog, tog[15:0]);
		@(negedge mclk);
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under a thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// every code change takes the oldest note
	always @(code) begin
		if (armed) begin
			#1;
			if (q.size() == 0) begin
				chk_count("queued notes", 16'h0001, 16'h0000);
			end else begin
				e = q.pop_front();
				chk_code("code", e, code);
				chk_flag("major stop", e inside {16'h1605, 16'h1606, 16'h1607}, stop);
				chk_flag("warn active", e[15:8] == 8'h18, warn);
			end
		end
	end
	//////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		nrst = 1;
		armed = 1;
		// every warning kind on both channels, raised then cleared
		for (int k = 0; k < 10; k++) begin
			q.push_back(16'h1800 + 16'(k));
			evt(k % 2, set_e[k / 2]);
			q.push_back(16'h0000);
			evt(k % 2, clr_e[k / 2]);
		end
		// warning blinks at half period four
		q.push_back(16'h1800);
		evt(0, 8'h80);
		blinks(16'h0004);
		q.push_back(16'h0000);
		evt(0, 8'h40);
		// disabled alarms on ch2 leave code at zero
		cfg2 = 2'h0;
		evt(1, 8'h80);
		evt(1, 8'h01);
		// random alarm enables on ch2: only enabled alarms reach the code
		cfg2 = 2'($random(seed));
		if (cfg2.ovf_alarm_en) q.push_back(16'h1801);
		evt(1, 8'h80);
		if (cfg2.zero_alarm_en && !cfg2.ovf_alarm_en) q.push_back(16'h1809);
		evt(1, 8'h01);
		if (cfg2 != 2'h0) q.push_back(16'h0000);
		evt(1, 8'h40);
		cfg2 = 2'h3;
		// frozen clock enable: random events, faults and a download are all ignored
		ce = 0;
		{cnt_lost, set_lost, cfg_bad, dl_req} = 4'($random(seed));
		evt($random(seed) & 1, 8'($random(seed)));
		{cnt_lost, set_lost, cfg_bad, dl_req} = 4'h0;
		@(negedge mclk);
		ce = 1;
		// mismatch follows its level and halts the cpu
		q.push_back(16'h1607);
		cfg_bad = 1;
		gap();
		chk_flag("cpu halted", 1'b1, halted);
		q.push_back(16'h0000);
		cfg_bad = 0;
		gap();
		// lost settings hold until a download
		q.push_back(16'h1606);
		set_lost = 1;
		@(negedge mclk);
		set_lost = 0;
		gap();
		gap();
		q.push_back(16'h0000);
		dl_req = 1;
		@(negedge mclk);
		dl_req = 0;
		gap();
		// lost count lights steadily, power cycle clears it
		q.push_back(16'h1605);
		cnt_lost = 1;
		@(negedge mclk);
		cnt_lost = 0;
		gap();
		blinks(16'h0000);
		chk_flag("led steady", 1'b1, led);
		q.push_back(16'h0000);
		nrst = 0;
		repeat (2) @(negedge mclk);
		nrst = 1;
		gap();
		chk_count("notes left", 16'h0000, 16'(q.size()));
		complete_run();
	end
endmodule
